//--- logic/atc_timing_ctl.sv
// Purpose: Converter timing control register with clear/set/invert aliases
//          and the conversion clock and auto-sample timing derived from it
// Assumes: hclk is the peripheral bus clock; rc_osc_tick is a synchronous
//          one-cycle pulse per internal RC oscillator period
// Notes:   Zero-wait AHB-Lite slave, always OKAY
//
// Notes on behaviour
// (RULE1) Source bit one picks RC oscillator; zero picks bus-clock divider.
// (RULE2) Five-bit sample field gives sampling length in conversion clock periods.
// (RULE3) Divided conversion period is bus period times two times divider plus one.
// (RULE4) Clear alias write zeroes every control bit written as one.
// (RULE5) Set alias write forces to one every control bit written as one.
// (RULE6) Invert alias write toggles every control bit written as one.
// (RULE7) Alias writes never touch unimplemented or reserved bit positions.
// (RULE8) Alias reads return no meaningful value; software ignores them.
// (RULE9) Zero bits in an invert alias write leave the control bits unchanged.
// (RULE10) Reserved bits 31..16 and 14..13 read zero; software writes zero.
`timescale 1ns/1ps

module atc_timing_ctl
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        rc_osc_tick,
    input  wire logic        sample_start,
    output logic             conv_clock_source_select,
    output logic      [4:0]  auto_sample_duration,
    output logic      [7:0]  conv_clock_divider,
    output logic             conv_clock,
    output logic             conv_tick,
    output logic             sampling,
    output logic             sample_done
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed
    {
        logic [31:0]       ctl;
        logic              wr_pend;
        logic [1:0]        wr_idx;
        logic [31:0]       rdata;
        logic              ready;
        logic              resp;
        logic [7:0]        div_cnt;
        logic              cclk;
        logic              ctick;
        atc_pkg::atc_samp_t samp;
        logic [4:0]        samp_cnt;
        logic              done;
    } atc_state_t;

    atc_state_t q;
    atc_state_t d;

    localparam atc_state_t STATE_RESET = '{
        ctl:      atc_pkg::CTL_RESET,
        wr_pend:  1'b0,
        wr_idx:   2'h0,
        rdata:    32'h0000_0000,
        ready:    1'b1,
        resp:     1'b0,
        div_cnt:  8'h00,
        cclk:     1'b0,
        ctick:    1'b0,
        samp:     atc_pkg::ATC_IDLE,
        samp_cnt: 5'h00,
        done:     1'b0
    };

    function automatic logic [1:0] reg_index(input logic [31:0] addr);
        reg_index = addr[atc_pkg::ADDR_HI:atc_pkg::ADDR_LO];
    endfunction

    function automatic logic is_mapped(input logic [31:0] addr);
        is_mapped = (addr[31:4] == 28'h0000000) && (addr[1:0] == 2'h0);
    endfunction

    logic        take;
    logic [31:0] wmask;
    logic [31:0] ctl_n;
    logic [7:0]  div_v;
    logic [4:0]  samc_v;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        d     = q;
        take  = hsel && hready && (htrans == atc_pkg::HTRANS_NONSEQ);
        wmask = hwdata & atc_pkg::CTL_MASK;                          // RULE7 RULE10
        ctl_n = q.ctl;
        div_v = q.ctl[atc_pkg::DIV_MSB:atc_pkg::DIV_LSB];
        samc_v = q.ctl[atc_pkg::SAMC_MSB:atc_pkg::SAMC_LSB];

        // Data phase of a write lands in the control register
        if (q.wr_pend)
        begin
            unique case (q.wr_idx)
                atc_pkg::OFS_CTL[3:2]: ctl_n = wmask;
                atc_pkg::OFS_CLR[3:2]: ctl_n = q.ctl & ~wmask;               // RULE4
                atc_pkg::OFS_SET[3:2]: ctl_n = q.ctl | wmask;                // RULE5
                atc_pkg::OFS_INV[3:2]: ctl_n = q.ctl ^ wmask;                // RULE6 RULE9
            endcase
        end
        d.ctl = ctl_n;

        // Address phase; reads see a write completing in the same edge
        d.wr_pend = take && hwrite && is_mapped(haddr);
        d.wr_idx  = reg_index(haddr);
        d.ready   = 1'b1;
        d.resp    = 1'b0;
        if (take && !hwrite)
        begin
            if (is_mapped(haddr) && reg_index(haddr) == atc_pkg::OFS_CTL[3:2])
            begin
                d.rdata = ctl_n & atc_pkg::CTL_MASK;                 // RULE10
            end
            else
            begin
                d.rdata = atc_pkg::ALIAS_RD;                         // RULE8
            end
        end

        // ------------------------------------------------------------
        // Conversion clock
        // ------------------------------------------------------------
        d.ctick = 1'b0;
        if (q.ctl[atc_pkg::SRC_BIT])
        begin
            // RC source: one conversion period per oscillator tick
            d.div_cnt = 8'h00;
            d.ctick   = rc_osc_tick;                                 // RULE1
            d.cclk    = rc_osc_tick;
        end
        else if (q.div_cnt >= div_v)
        begin
            // Half period is divider plus one bus periods
            d.div_cnt = 8'h00;                                       // RULE3
            d.cclk    = ~q.cclk;
            d.ctick   = ~q.cclk;                                     // RULE1
        end
        else
        begin
            d.div_cnt = q.div_cnt + 8'h01;
        end

        // ------------------------------------------------------------
        // Auto-sample timer
        // ------------------------------------------------------------
        d.done = 1'b0;
        unique case (q.samp)
            atc_pkg::ATC_IDLE:
            begin
                d.samp_cnt = 5'h00;
                if (sample_start)
                begin
                    d.samp = atc_pkg::ATC_SAMPLE;
                end
            end
            atc_pkg::ATC_SAMPLE:
            begin
                // Zero is not a legal length; it runs 32 periods
                if (q.ctick)
                begin
                    d.samp_cnt = q.samp_cnt + 5'h01;
                    if (q.samp_cnt + 5'h01 == samc_v)                // RULE2
                    begin
                        d.samp = atc_pkg::ATC_IDLE;
                        d.done = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            q <= STATE_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign hrdata                   = q.rdata;
    assign hreadyout                = q.ready;
    assign hresp                    = q.resp;
    assign conv_clock_source_select = q.ctl[atc_pkg::SRC_BIT];
    assign auto_sample_duration     = q.ctl[atc_pkg::SAMC_MSB:atc_pkg::SAMC_LSB];
    assign conv_clock_divider       = q.ctl[atc_pkg::DIV_MSB:atc_pkg::DIV_LSB];
    assign conv_clock               = q.cclk;
    assign conv_tick                = q.ctick;
    assign sampling                 = (q.samp == atc_pkg::ATC_SAMPLE);
    assign sample_done              = q.done;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Gap between conversion ticks, spoilt by any control write
    logic [9:0] a_gap;
    logic       a_dirty;
    logic [5:0] a_samp_ticks;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            a_gap        <= 10'h000;
            a_dirty      <= 1'b1;
            a_samp_ticks <= 6'h00;
        end
        else
        begin
            a_gap   <= conv_tick ? 10'h001 : a_gap + 10'h001;
            a_dirty <= q.wr_pend || conv_clock_source_select ||
                       (a_dirty && !conv_tick);
            if (!sampling)
            begin
                a_samp_ticks <= 6'h00;
            end
            else if (conv_tick)
            begin
                a_samp_ticks <= a_samp_ticks + 6'h01;
            end
        end
    end

    a_rc_tick_follow: assert property (                                    // RULE1
        @(posedge hclk) disable iff (!hresetn)
        conv_clock_source_select && !q.wr_pend && rc_osc_tick |=> conv_tick)
        else $error("RC tick not passed to conversion clock");

    a_bus_period: assert property (                                        // RULE3
        @(posedge hclk) disable iff (!hresetn)
        conv_tick && !a_dirty && !conv_clock_source_select
        |-> a_gap == 10'(atc_pkg::DIV_SCALE * (int'(conv_clock_divider) + 1)))
        else $error("Conversion period does not match divider");

    a_clear_alias: assert property (                                       // RULE4
        @(posedge hclk) disable iff (!hresetn)
        q.wr_pend && q.wr_idx == atc_pkg::OFS_CLR[3:2]
        |=> q.ctl == ($past(q.ctl) & ~($past(hwdata) & atc_pkg::CTL_MASK)))
        else $error("Clear alias result wrong");

    a_set_alias: assert property (                                         // RULE5
        @(posedge hclk) disable iff (!hresetn)
        q.wr_pend && q.wr_idx == atc_pkg::OFS_SET[3:2]
        |=> q.ctl == ($past(q.ctl) | ($past(hwdata) & atc_pkg::CTL_MASK)))
        else $error("Set alias result wrong");

    a_invert_alias: assert property (                                      // RULE6 RULE9
        @(posedge hclk) disable iff (!hresetn)
        q.wr_pend && q.wr_idx == atc_pkg::OFS_INV[3:2]
        |=> q.ctl == ($past(q.ctl) ^ ($past(hwdata) & atc_pkg::CTL_MASK)))
        else $error("Invert alias result wrong");

    a_reserved_zero: assert property (                                     // RULE7 RULE10
        @(posedge hclk) disable iff (!hresetn)
        (q.ctl & ~atc_pkg::CTL_MASK) == 32'h0000_0000)
        else $error("Reserved control bit set");

    a_alias_read: assert property (                                        // RULE8
        @(posedge hclk) disable iff (!hresetn)
        hsel && hready && htrans == atc_pkg::HTRANS_NONSEQ && !hwrite &&
        haddr[3:2] != 2'h0 |=> hrdata == atc_pkg::ALIAS_RD)
        else $error("Alias read not zero");

    a_sample_len: assert property (                                        // RULE2
        @(posedge hclk) disable iff (!hresetn)
        sample_done && !$past(q.wr_pend, 1) && auto_sample_duration != 5'h00
        |-> a_samp_ticks == {1'b0, auto_sample_duration})
        else $error("Sampling length wrong");

    a_bus_okay: assert property (
        @(posedge hclk) disable iff (!hresetn)
        hreadyout && !hresp)
        else $error("Bus not ready or error response");

endmodule

//--- pkg/atc_pkg.sv
// Purpose: Shared constants for the converter timing control block
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes:   Alias offsets follow the control register in word order
package atc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_CTL = 4'h0;
    localparam logic [3:0] OFS_CLR = 4'h4;
    localparam logic [3:0] OFS_SET = 4'h8;
    localparam logic [3:0] OFS_INV = 4'hc;
    localparam int         ADDR_LO = 2;
    localparam int         ADDR_HI = 3;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int SRC_BIT  = 15;
    localparam int SAMC_LSB = 8;
    localparam int SAMC_MSB = 12;
    localparam int DIV_LSB  = 0;
    localparam int DIV_MSB  = 7;

    // Implemented bits: 15, 12..0
    localparam logic [31:0] CTL_MASK  = 32'h0000_9fff;
    localparam logic [31:0] CTL_RESET = 32'h0000_0000;
    localparam logic [31:0] ALIAS_RD  = 32'h0000_0000;

    // ------------------------------------------------------------
    // Bus encodings
    // ------------------------------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int HCLK_PERIOD_NS = 10;
    localparam int DIV_SCALE      = 2;

    typedef enum logic [1:0]
    {
        ATC_IDLE   = 2'b01,
        ATC_SAMPLE = 2'b10
    } atc_samp_t;

endpackage

//--- verif/adc_timing_control_register_tb_top.sv
// Purpose: Self-checking bench for the converter timing control register
// Assumes: Zero-wait AHB-Lite slave with hready tied to its own hreadyout
// Notes:   Table rows cover direct and alias writes; timing checked by directed compares after
`timescale 1ns/1ps

`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_fail++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, (got), (exp)); end end

module adc_timing_control_register_tb_top;
    logic        hclk        = 1'b0;
    logic        hresetn     = 1'b0;
    logic        hsel        = 1'b0;
    logic [31:0] haddr       = 32'h0000_0000;
    logic [1:0]  htrans      = 2'h0;
    logic        hwrite      = 1'b0;
    logic [2:0]  hsize       = atc_pkg::HSIZE_WORD;
    logic [31:0] hwdata      = 32'h0000_0000;
    logic        rc_osc_tick = 1'b0;
    logic        sample_start = 1'b0;
    logic        rc_en       = 1'b0;
    logic [2:0]  rc_cnt      = 3'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        src;
    logic [4:0]  samc;
    logic [7:0]  div;
    logic        conv_clock;
    logic        conv_tick;
    logic        sampling;
    logic        sample_done;
    logic [31:0] rd;
    int          n_fail      = 0;
    int          compares    = 0;
    int          n;
    logic [3:0]  r_a [8] = '{4'h0, 4'h0, 4'h8, 4'h4, 4'hc, 4'hc, 4'h4, 4'h8};
    logic [31:0] r_w [8] = '{32'hffff_ffff, 32'h0000_1234, 32'hffff_8001, 32'h0000_8001,
                             32'hffff_ffff, 32'h0000_8001, 32'hffff_ffff, 32'h6000_6000};
    logic [31:0] r_e [8] = '{32'h0000_9fff, 32'h0000_1234, 32'h0000_9235, 32'h0000_1234,
                             32'h0000_8dcb, 32'h0000_0dca, 32'h0000_0000, 32'h0000_0000};
    logic [4:0]  n_samp [3] = '{5'h01, 5'h03, 5'h1f};

    always #5 hclk = ~hclk;

    // RC oscillator stand-in: one tick every five bus cycles
    always @(posedge hclk)
    begin
        rc_cnt      <= (rc_cnt == 3'h4) ? 3'h0 : rc_cnt + 3'h1;
        rc_osc_tick <= rc_en & (rc_cnt == 3'h0);
    end

    atc_timing_ctl u_atc_timing_ctl
    (
        .hclk                     (hclk),
        .hresetn                  (hresetn),
        .hsel                     (hsel),
        .haddr                    (haddr),
        .htrans                   (htrans),
        .hwrite                   (hwrite),
        .hsize                    (hsize),
        .hwdata                   (hwdata),
        .hready                   (hreadyout),
        .hrdata                   (hrdata),
        .hreadyout                (hreadyout),
        .hresp                    (hresp),
        .rc_osc_tick              (rc_osc_tick),
        .sample_start             (sample_start),
        .conv_clock_source_select (src),
        .auto_sample_duration     (samc),
        .conv_clock_divider       (div),
        .conv_clock               (conv_clock),
        .conv_tick                (conv_tick),
        .sampling                 (sampling),
        .sample_done              (sample_done)
    );

    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= atc_pkg::HTRANS_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? d : 32'h0000_0000;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    // Period of conv_clock in bus cycles; earlier periods may be irregular
    task automatic gap(output int g);
        logic p;
        p = conv_clock;
        repeat (3)
        begin
            g = 0;
            do begin p = conv_clock; @(negedge hclk); g++; end
            while (!(conv_clock === 1'b1 && p === 1'b0) && g < 2000);
        end
    endtask

    task automatic results();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge hclk);
        n_fail++;
        results();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, 32'h0, 32'h0);
        `CHK(rd, atc_pkg::CTL_RESET)
        `CHK({hreadyout, hresp}, 2'b10)
        for (int i = 0; i < 8; i++)
        begin
            ahb(1'b1, {28'h0, r_a[i]}, r_w[i]);
            ahb(1'b0, {28'h0, r_a[i]}, 32'h0); // Alias read must not disturb ctl
            ahb(1'b0, 32'h0, 32'h0);
            `CHK(rd, r_e[i])
            `CHK({16'h0, src, 2'b00, samc, div}, r_e[i])
        end
        // Unmapped write ignored, read zero
        ahb(1'b1, 32'h0, 32'h0000_0a5a);
        ahb(1'b1, 32'h10, 32'hffff_ffff);
        ahb(1'b0, 32'h0, 32'h0);
        `CHK(rd, 32'h0000_0a5a)
        ahb(1'b0, 32'h10, 32'h0);
        `CHK(rd, 32'h0000_0000)
        // Bus-derived conversion clock at three divider settings
        foreach (r_w[i])
        begin
            if (i < 3)
            begin
                ahb(1'b1, 32'h0, {24'h0, (i == 0) ? 8'h00 : (i == 1) ? 8'h02 : 8'hff});
                gap(n);
                `CHK(n, (i == 0) ? 2 : (i == 1) ? 6 : 512)
            end
        end
        // RC source ignores the divider and follows the oscillator ticks
        ahb(1'b1, 32'h0, 32'h0000_8000);
        n = 0;
        repeat (60) begin @(negedge hclk); n += int'(conv_tick === 1'b1); end
        `CHK(n, 0)
        @(posedge hclk);
        rc_en <= 1'b1;
        gap(n);
        `CHK(n, 5)
        // Auto-sample length in conversion periods; a second start is refused
        foreach (n_samp[j])
        begin
            ahb(1'b1, 32'h0, {19'h0, n_samp[j], 8'h00});
            n = 0;
            for (int k = 0; k < 200 && sample_done !== 1'b1; k++)
            begin
                @(posedge hclk);
                sample_start <= (k == 0 || k == 4);
                #1;
                if (sampling === 1'b1 && conv_tick === 1'b1)
                    n++;
            end
            `CHK(n, int'(n_samp[j]))
            `CHK(sampling, 1'b0)
            `CHK(sample_done, 1'b1)
            @(posedge hclk);
        end
        // Reset in mid-run clears the fields
        ahb(1'b1, 32'h0, 32'h0000_9fff);
        ahb(1'b0, 32'h0, 32'h0);
        `CHK(rd, 32'h0000_9fff)
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        #1;
        `CHK({src, samc, div, sampling}, 15'h0000)
        `CHK({hrdata, hreadyout, hresp, conv_clock, conv_tick, sample_done}, {32'h0000_0000, 5'h10})
        @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, 32'h0, 32'h0);
        `CHK(rd, atc_pkg::CTL_RESET)
        results();
    end
endmodule
